// *** logic/ilb_bridge.sv ***
// serial host slave and command interpreter of the line bridge
`timescale 1ns/1ps
`default_nettype none
`include "ilb_regs.svh"
module ilb_bridge
  import ilb_pkg::*;
#(
  parameter int FIFO_DEPTH = `ILB_FIFO_DEPTH
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  input  wire logic [2:0] i_addr,
  output logic            o_busy,
  output logic [3:0]      o_cfg,
  output logic [2:0]      o_chan,
  output logic            o_req_valid,
  input  wire logic       i_req_ready,
  output ilb_req_t        o_req,
  input  wire logic       i_line_done,
  input  wire logic [7:0] i_line_rdata,
  input  wire logic       i_line_presence,
  input  wire logic       i_line_short,
  input  wire logic       i_line_bit
);
  ilb_st_t st_r, st_nxt;
  logic    fifo_rdy;
  logic    rise, fall, start, stop, byte_end, acc;

  // code whose high nibble mirrors the inverted low nibble
  function automatic logic cpl_ok(input logic [7:0] b);
    return b[7:4] == ~b[3:0];
  endfunction

  // register chosen by the read pointer
  function automatic logic [7:0] rd_mux(input ilb_st_t s);
    case (s.ptr)
      `ILB_PTR_RDATA: return s.rdata;
      `ILB_PTR_CHAN:  return {~{1'b0, s.chan}, 1'b0, s.chan};
      `ILB_PTR_CFG:   return {~s.cfg, s.cfg};
      default: begin
        rd_mux = 8'h00;
        rd_mux[`ILB_ST_BUSY]     = s.busy;
        rd_mux[`ILB_ST_PRESENCE] = s.pres;
        rd_mux[`ILB_ST_SHORT]    = s.shrt;
        rd_mux[`ILB_ST_SBIT]     = s.sbit;
      end
    endcase
  endfunction

  // bus events, seen only on the second and third sync stages
  assign rise  = st_r.scl_s & ~st_r.scl_p;
  assign fall  = ~st_r.scl_s & st_r.scl_p;
  assign start = st_r.scl_s & st_r.scl_p & st_r.sda_p & ~st_r.sda_s;
  assign stop  = st_r.scl_s & st_r.scl_p & ~st_r.sda_p & st_r.sda_s;
  assign byte_end = fall && st_r.fsm == ILB_WR_BYTE
                    && st_r.cnt == `ILB_BYTE_END;

  always_comb begin
    st_nxt = st_r;
    st_nxt.push = 1'b0;
    acc = 1'b0;
    // clock pin is only sampled, never driven
    st_nxt.scl_m  = i_scl;
    st_nxt.scl_s  = st_r.scl_m;
    st_nxt.scl_p  = st_r.scl_s;
    st_nxt.sda_m  = i_sda;
    st_nxt.sda_s  = st_r.sda_m;
    st_nxt.sda_p  = st_r.sda_s;
    st_nxt.addr_m = i_addr;
    st_nxt.addr_s = st_r.addr_m;
    // line sequence finished: keep outcome, drop busy
    if (i_line_done && st_r.busy) begin
      st_nxt.busy = 1'b0;
      st_nxt.pres = i_line_presence;
      st_nxt.shrt = i_line_short;
      st_nxt.sbit = i_line_bit;
      if (st_r.last_op == `ILB_CMD_LINE_READ)
        st_nxt.rdata = i_line_rdata;
    end
    if (stop) begin
      st_nxt.fsm    = ILB_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else if (start) begin
      st_nxt.fsm    = ILB_ADDR;
      st_nxt.cnt    = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end else if (rise) begin
      unique case (st_r.fsm)
        ILB_ADDR, ILB_WR_BYTE: begin
          st_nxt.sh  = {st_r.sh[6:0], st_r.sda_s};
          st_nxt.cnt = st_r.cnt + 4'h1;
        end
        ILB_RD_BYTE: st_nxt.cnt = st_r.cnt + 4'h1;
        ILB_RD_ACK:  st_nxt.mack = ~st_r.sda_s;
        ILB_IDLE, ILB_ADDR_ACK, ILB_WR_ACK: ;
      endcase
    end else if (fall) begin
      unique case (st_r.fsm)
        ILB_ADDR: if (st_r.cnt == `ILB_BYTE_END) begin
          if (st_r.sh[7:1] == {`ILB_ADDR_HI, st_r.addr_s}) begin
            st_nxt.fsm    = ILB_ADDR_ACK;
            st_nxt.sda_oe = 1'b1;
            st_nxt.rw     = st_r.sh[0];
          end else begin
            st_nxt.fsm = ILB_IDLE;
          end
        end
        ILB_ADDR_ACK: begin
          st_nxt.cnt = 4'h0;
          st_nxt.idx = 2'd0;
          if (st_r.rw) begin
            st_nxt.fsm    = ILB_RD_BYTE;
            st_nxt.sh     = rd_mux(st_r);
            st_nxt.sda_oe = ~st_nxt.sh[7];
          end else begin
            st_nxt.fsm    = ILB_WR_BYTE;
            st_nxt.sda_oe = 1'b0;
          end
        end
        ILB_WR_BYTE: if (st_r.cnt == `ILB_BYTE_END) begin
          st_nxt.fsm = ILB_WR_ACK;
          st_nxt.cnt = 4'h0;
          if (st_r.idx == 2'd0) begin
            st_nxt.cmd = st_r.sh;
            // only pointer moves pass while busy
            if (!st_r.busy || st_r.sh == `ILB_CMD_PTR_SET) begin
              unique case (st_r.sh)
                `ILB_CMD_DEV_RESET: begin
                  acc = 1'b1;
                  st_nxt.cfg  = 4'h0;
                  st_nxt.chan = 3'h0;
                  st_nxt.ptr  = `ILB_PTR_STATUS;
                  st_nxt.pres = 1'b0;
                  st_nxt.shrt = 1'b0;
                  st_nxt.sbit = 1'b0;
                end
                `ILB_CMD_CFG_WRITE, `ILB_CMD_CHAN_CHOOSE, `ILB_CMD_PTR_SET,
                `ILB_CMD_LINE_WRITE, `ILB_CMD_LINE_SBIT,
                `ILB_CMD_LINE_TRIPLE: acc = 1'b1;
                // full queue refuses rather than losing the operation
                `ILB_CMD_LINE_RESET, `ILB_CMD_LINE_READ: acc = fifo_rdy;
                default: acc = 1'b0;
              endcase
              if (acc && (st_r.sh == `ILB_CMD_LINE_RESET
                          || st_r.sh == `ILB_CMD_LINE_READ)) begin
                st_nxt.push    = 1'b1;
                st_nxt.busy    = 1'b1;
                st_nxt.last_op = st_r.sh;
                st_nxt.req     = '{code: st_r.sh, data: 8'h00};
              end
            end
          end else if (st_r.idx == 2'd1) begin
            unique case (st_r.cmd)
              `ILB_CMD_PTR_SET: begin
                acc = st_r.sh == `ILB_PTR_STATUS || st_r.sh == `ILB_PTR_RDATA
                   || st_r.sh == `ILB_PTR_CHAN || st_r.sh == `ILB_PTR_CFG;
                if (acc)
                  st_nxt.ptr = st_r.sh;
              end
              `ILB_CMD_CFG_WRITE: begin
                acc = cpl_ok(st_r.sh);
                if (acc)
                  st_nxt.cfg = st_r.sh[3:0];
              end
              `ILB_CMD_CHAN_CHOOSE: begin
                acc = cpl_ok(st_r.sh) && !st_r.sh[3];
                if (acc)
                  st_nxt.chan = st_r.sh[2:0];
              end
              `ILB_CMD_LINE_WRITE, `ILB_CMD_LINE_SBIT,
              `ILB_CMD_LINE_TRIPLE: begin
                acc = fifo_rdy;
                if (acc) begin
                  st_nxt.push    = 1'b1;
                  st_nxt.busy    = 1'b1;
                  st_nxt.last_op = st_r.cmd;
                  st_nxt.req     = '{code: st_r.cmd, data: st_r.sh};
                end
              end
              default: acc = 1'b0;
            endcase
          end
          st_nxt.sda_oe = acc;
          st_nxt.nacked = ~acc;
        end
        ILB_WR_ACK: begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.fsm    = st_r.nacked ? ILB_IDLE : ILB_WR_BYTE;
          if (st_r.idx != 2'd2)
            st_nxt.idx = st_r.idx + 2'd1;
        end
        ILB_RD_BYTE: if (st_r.cnt == `ILB_BYTE_END) begin
          st_nxt.fsm    = ILB_RD_ACK;
          st_nxt.sda_oe = 1'b0;
        end else begin
          st_nxt.sh     = {st_r.sh[6:0], 1'b0};
          st_nxt.sda_oe = ~st_r.sh[6];
        end
        // master ack: same register again, refreshed
        ILB_RD_ACK: if (st_r.mack) begin
          st_nxt.fsm    = ILB_RD_BYTE;
          st_nxt.cnt    = 4'h0;
          st_nxt.sh     = rd_mux(st_r);
          st_nxt.sda_oe = ~st_nxt.sh[7];
        end else begin
          st_nxt.fsm = ILB_IDLE;
        end
        ILB_IDLE: ;
      endcase
    end
  end

  // single state register; clock and data syncs settle high like an idle bus, address syncs low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.scl_m <= 1'b1;
      st_r.scl_s <= 1'b1;
      st_r.scl_p <= 1'b1;
      st_r.sda_m <= 1'b1;
      st_r.sda_s <= 1'b1;
      st_r.sda_p <= 1'b1;
      st_r.ptr   <= `ILB_PTR_STATUS;
    end else begin
      st_r <= st_nxt;
    end
  end

  ilb_fifo #(
    .WIDTH (`ILB_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (st_r.push),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (st_r.req),
    .o_out_valid (o_req_valid),
    .i_out_ready (i_req_ready),
    .o_out_data  (o_req)
  );

  // data pin level is a constant low, only the enable moves
  assign o_sda_o  = st_r.sda_lvl;
  assign o_sda_oe = st_r.sda_oe;
  assign o_busy   = st_r.busy;
  assign o_cfg    = st_r.cfg;
  assign o_chan   = st_r.chan;

  property p_busy_refuse;
    @(posedge i_clk) disable iff (!i_rst_b)
    byte_end && st_r.idx == 2'd0 && st_r.busy
      && st_r.sh != `ILB_CMD_PTR_SET |=> !o_sda_oe && st_r.nacked;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("command taken while busy");

  property p_ptr_cfg;
    @(posedge i_clk) disable iff (!i_rst_b)
    byte_end && st_r.idx == 2'd1 && st_r.cmd == `ILB_CMD_PTR_SET
      && st_r.sh == `ILB_PTR_CFG |=> o_sda_oe && st_r.ptr == `ILB_PTR_CFG;
  endproperty
  a_ptr_cfg: assert property (p_ptr_cfg)
    else $error("configuration pointer not taken");

  property p_ptr_bad;
    @(posedge i_clk) disable iff (!i_rst_b)
    byte_end && st_r.idx == 2'd1 && st_r.cmd == `ILB_CMD_PTR_SET
      && st_r.sh == 8'hE5 |=> !o_sda_oe && st_r.ptr == $past(st_r.ptr);
  endproperty
  a_ptr_bad: assert property (p_ptr_bad)
    else $error("bad pointer code accepted");

  property p_reset_result;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_line_done && st_r.busy |=> st_r.pres == $past(i_line_presence)
      && !o_busy;
  endproperty
  a_reset_result: assert property (p_reset_result)
    else $error("line outcome lost");

  property p_wr_no_capture;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_line_done && st_r.last_op == `ILB_CMD_LINE_WRITE
      |=> $stable(st_r.rdata);
  endproperty
  a_wr_no_capture: assert property (p_wr_no_capture)
    else $error("write byte changed read data");

  property p_ptr_while_busy;
    @(posedge i_clk) disable iff (!i_rst_b)
    byte_end && st_r.idx == 2'd0 && st_r.sh == `ILB_CMD_PTR_SET
      |=> o_sda_oe ##1 o_sda_oe;
  endproperty
  a_ptr_while_busy: assert property (p_ptr_while_busy)
    else $error("pointer command refused");

  property p_pin_low;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_sda_oe |-> o_sda_o == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("data pin driven high");

  property p_surplus;
    @(posedge i_clk) disable iff (!i_rst_b)
    byte_end && st_r.idx == 2'd2 |=> !o_sda_oe;
  endproperty
  a_surplus: assert property (p_surplus)
    else $error("surplus byte acknowledged");

  property p_reread;
    @(posedge i_clk) disable iff (!i_rst_b)
    fall && st_r.fsm == ILB_RD_ACK && st_r.mack
      |=> st_r.sh == rd_mux($past(st_r));
  endproperty
  a_reread: assert property (p_reread)
    else $error("read byte not from pointed register");

  property p_busy_on_push;
    @(posedge i_clk) disable iff (!i_rst_b)
    st_r.push |-> o_busy;
  endproperty
  a_busy_on_push: assert property (p_busy_on_push)
    else $error("line command queued without busy");
endmodule
`default_nettype wire

// *** logic/ilb_fifo.sv ***
// line request queue with registered read side
`timescale 1ns/1ps
`default_nettype none
module ilb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp, rp;
    logic [AW:0]                 cnt;
    logic                        in_ready, out_valid;
    logic [WIDTH-1:0]            out_data;
  } ilb_fifo_st_t;
  ilb_fifo_st_t st_r, st_nxt;

  // writes and output refills both act on the old count
  always_comb begin
    st_nxt = st_r;
    if (i_in_valid && st_r.in_ready) begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (!st_r.out_valid || i_out_ready) begin
      st_nxt.out_valid = (st_r.cnt != '0);
      if (st_r.cnt != '0) begin
        st_nxt.out_data = st_r.mem[st_r.rp];
        st_nxt.rp = st_r.rp + 1'b1;
      end
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(i_in_valid && st_r.in_ready)
               - (AW+1)'((!st_r.out_valid || i_out_ready) && st_r.cnt != '0);
    st_nxt.in_ready = (st_nxt.cnt < (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.in_ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_in_ready  = st_r.in_ready;
  assign o_out_valid = st_r.out_valid;
  assign o_out_data  = st_r.out_data;
endmodule
`default_nettype wire

// *** logic/ilb_pkg.sv ***
// types shared by the line bridge modules
package ilb_pkg;
  typedef enum logic [2:0] {
    ILB_IDLE, ILB_ADDR, ILB_ADDR_ACK, ILB_WR_BYTE, ILB_WR_ACK, ILB_RD_BYTE,
    ILB_RD_ACK
  } ilb_fsm_t;
  // one queued line operation: command code and its data byte
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } ilb_req_t;
  typedef struct packed {
    ilb_fsm_t   fsm;
    logic       scl_m, scl_s, scl_p;
    logic       sda_m, sda_s, sda_p;
    logic [2:0] addr_m, addr_s;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] idx;
    logic [7:0] cmd;
    logic       rw, nacked, mack;
    logic       sda_oe, sda_lvl;
    logic       busy;
    logic [7:0] ptr;
    logic [3:0] cfg;
    logic [2:0] chan;
    logic [7:0] rdata;
    logic       pres, shrt, sbit;
    logic [7:0] last_op;
    logic       push;
    ilb_req_t   req;
  } ilb_st_t;
endpackage

// *** logic/ilb_regs.svh ***
// command codes, pointer codes, status layout and sizes of the line bridge
`ifndef ILB_REGS_SVH
`define ILB_REGS_SVH
`define ILB_CMD_DEV_RESET   8'hF0
`define ILB_CMD_CFG_WRITE   8'hD2
`define ILB_CMD_CHAN_CHOOSE 8'hC3
`define ILB_CMD_PTR_SET     8'hE1
`define ILB_CMD_LINE_RESET  8'hB4
`define ILB_CMD_LINE_WRITE  8'hA5
`define ILB_CMD_LINE_READ   8'h96
`define ILB_CMD_LINE_SBIT   8'h87
`define ILB_CMD_LINE_TRIPLE 8'h78
`define ILB_PTR_STATUS      8'hF0
`define ILB_PTR_RDATA       8'hE1
`define ILB_PTR_CHAN        8'hD2
`define ILB_PTR_CFG         8'hC3
`define ILB_ADDR_HI         4'h3
`define ILB_ST_BUSY         0
`define ILB_ST_PRESENCE     1
`define ILB_ST_SHORT        2
`define ILB_ST_SBIT         5
`define ILB_BYTE_END        4'h8
`define ILB_FIFO_DEPTH      16
`define ILB_FIFO_WIDTH      16
`endif

// *** verification/ilb_bridge_bench.sv ***
// self-checking bench of the line bridge
`timescale 1ns/1ps
`default_nettype none
`include "ilb_regs.svh"
module ilb_bridge_bench;
  import ilb_pkg::*;
  logic       clk, rst_b, scl, pull, sda_w, sda_o, sda_oe, busy;
  logic       req_valid, req_ready, done, pres, shrt, lbit;
  logic [2:0] addr, chan, c;
  logic [3:0] cfg, n;
  logic [7:0] rdata, d, r;
  logic [7:0] lc [2];
  ilb_req_t   req;
  int         bad_count, checked;
  // pull-up wins when nobody pulls the data wire
  assign sda_w = !(pull | sda_oe);
  initial clk = 1'b0;
  always #2 clk = ~clk;
  ilb_host_model host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_pull(pull));
  ilb_bridge ilb_bridge_inst (.i_clk(clk), .i_rst_b(rst_b), .i_scl(scl),
    .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr(addr),
    .o_busy(busy), .o_cfg(cfg), .o_chan(chan), .o_req_valid(req_valid),
    .i_req_ready(req_ready), .o_req(req), .i_line_done(done),
    .i_line_rdata(rdata), .i_line_presence(pres), .i_line_short(shrt),
    .i_line_bit(lbit));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // status byte from its flag bits: single bit, short, presence, busy
  function automatic logic [7:0] status_exp(input logic sb, input logic sh,
                                            input logic pr, input logic bz);
    return {2'b00, sb, 2'b00, sh, pr, bz};
  endfunction
  // one write access; a refused byte ends it with a stop
  task automatic wr(input logic [23:0] b, input int cnt,
                    input logic [3:0] exp);
    logic [3:0] acks;
    logic       a;
    acks = 4'h0;
    host.start_cond();
    host.send_byte({`ILB_ADDR_HI, addr, 1'b0}, a);
    acks[0] = a;
    for (int i = 0; i < cnt && a; i++) begin
      host.send_byte(b[23-8*i -: 8], a);
      acks[i+1] = a;
    end
    host.stop_cond();
    check(acks, exp);
  endtask
  // one read access of cnt bytes, or polling until idle
  task automatic rd(input int cnt, input logic poll, input logic [7:0] exp);
    logic [7:0] b;
    logic       a;
    host.start_cond();
    host.send_byte({`ILB_ADDR_HI, addr, 1'b1}, a);
    check(a, 1'b1);
    for (int k = 0; k < cnt; k++) begin
      host.recv_byte(k < cnt - 1, poll, b);
      if (poll && b[0] && cnt < 100)
        cnt++;
      else if (!poll)
        check(b, exp);
    end
    host.stop_cond();
    if (poll)
      check(b, exp);
    // a poll that never sees idle is a failure, not a silent stop
    if (cnt >= 100) begin
      bad_count++;
      summarize();
    end
  endtask
  // line engine stand-in: takes one request, then reports after dly
  task automatic line_op(input logic [7:0] code, input logic [7:0] dat,
                         input logic cmp, input int dly);
    int k;
    k = 0;
    while (!req_valid && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k == 5000) begin
      bad_count++;
      summarize();
    end
    check(req.code, code);
    if (cmp)
      check(req.data, dat);
    req_ready = 1'b1;
    @(negedge clk);
    req_ready = 1'b0;
    repeat (dly) @(negedge clk);
    check(busy, 1'b1);
    rdata = 8'($urandom);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    repeat (2) @(negedge clk);
    check(busy, 1'b0);
  endtask
  initial begin
    void'($urandom(72475));
    {rst_b, req_ready, done, pres, shrt, lbit, rdata} = '0;
    addr = 3'($urandom);
    lc = '{`ILB_CMD_LINE_SBIT, `ILB_CMD_LINE_TRIPLE};
    bad_count = 0;
    checked = 0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    rd(2, 1'b0, status_exp(1'b0, 1'b0, 1'b0, 1'b0));
    n = 4'($urandom);
    wr({`ILB_CMD_CFG_WRITE, ~n, n, 8'h00}, 2, 4'h7);
    check(cfg, n);
    wr({`ILB_CMD_PTR_SET, 8'hC3, 8'h00}, 2, 4'h7);
    rd(2, 1'b0, {~n, n});
    wr({`ILB_CMD_PTR_SET, 8'hE5, 8'h00}, 2, 4'h3);
    rd(1, 1'b0, {~n, n});
    wr({`ILB_CMD_PTR_SET, 8'hF0, 8'h5A}, 3, 4'h7);
    wr(24'h000000, 1, 4'h1);
    $display("test register access done");
    // outcome bits fixed before the poll so its expectation is known
    pres = 1'($urandom);
    shrt = 1'($urandom);
    fork
      begin
        wr({`ILB_CMD_LINE_RESET, 16'h0}, 1, 4'h3);
        wr({`ILB_CMD_LINE_WRITE, 16'h0}, 1, 4'h1);
        wr({`ILB_CMD_PTR_SET, 8'hF0, 8'h00}, 2, 4'h7);
        rd(1, 1'b1, status_exp(1'b0, shrt, pres, 1'b0));
      end
      line_op(`ILB_CMD_LINE_RESET, 8'h00, 1'b0, 4000);
    join
    $display("test line reset done");
    fork
      begin
        wr({`ILB_CMD_LINE_READ, 16'h0}, 1, 4'h3);
        wr({`ILB_CMD_PTR_SET, 8'hE1, 8'h00}, 2, 4'h7);
      end
      line_op(`ILB_CMD_LINE_READ, 8'h00, 1'b0, 2000);
    join
    r = rdata;
    rd(1, 1'b0, r);
    d = 8'($urandom);
    fork
      wr({`ILB_CMD_LINE_WRITE, d, 8'h00}, 2, 4'h7);
      line_op(`ILB_CMD_LINE_WRITE, d, 1'b1, 300);
    join
    rd(1, 1'b0, r);
    $display("test line bytes done");
    lbit = 1'($urandom);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      fork
        wr({lc[i], d, 8'h00}, 2, 4'h7);
        line_op(lc[i], d, 1'b1, 100);
      join
    end
    c = 3'($urandom);
    wr({`ILB_CMD_CHAN_CHOOSE, ~{1'b0, c}, 1'b0, c, 8'h00}, 2, 4'h7);
    check(chan, c);
    wr({`ILB_CMD_DEV_RESET, 16'h0}, 1, 4'h3);
    check({cfg, 1'b0, chan}, 8'h00);
    check(sda_o, 1'b0);
    $display("test commands done");
    summarize();
  end
endmodule
`default_nettype wire

// *** verification/ilb_host_model.sv ***
// serial bus master model driving the bridge host pins
`timescale 1ns/1ps
`default_nettype none
module ilb_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_pull
);
  // quarter bit in system clocks, well above the 4 the slave needs
  localparam int HALF = 10;
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  task automatic pause();
    repeat (HALF) @(negedge i_clk);
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic low, output logic seen);
    pause();
    o_pull = low;
    pause();
    o_scl = 1'b1;
    pause();
    seen = i_sda;
    pause();
    o_scl = 1'b0;
  endtask
  // also a repeated start: data released before the clock rises
  task automatic start_cond();
    pause();
    o_pull = 1'b0;
    pause();
    o_scl = 1'b1;
    pause();
    o_pull = 1'b1;
    pause();
    o_scl = 1'b0;
  endtask
  task automatic stop_cond();
    pause();
    o_pull = 1'b1;
    pause();
    o_scl = 1'b1;
    pause();
    o_pull = 1'b0;
    pause();
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!b[i], seen);
    end
    bit_io(1'b0, seen);
    ack = !seen;
  endtask
  // polling acknowledges while the busy bit still reads 1
  task automatic recv_byte(input logic more, input logic poll,
                           output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, seen);
      b[i] = seen;
    end
    bit_io(more | (poll & b[0]), seen);
  endtask
endmodule
`default_nettype wire
